// File: logic/div_shift_params.svh
// constants of the divide and barrel shift unit
// assumes: included by the package and the unit only
`ifndef DIV_SHIFT_PARAMS_SVH
`define DIV_SHIFT_PARAMS_SVH
`define DS_DATA_W    16
`define DS_IDX_W     4
`define DS_NREG      16
`define DS_AMT_W     4
`define DS_DIV_ITER  16
`define DS_QUO_IDX   4'h0
`define DS_REM_IDX   4'h1
`define DS_RST_WORD  16'h0000
`endif

// File: logic/div_shift_pkg.sv
// types of the divide and barrel shift unit
// assumes: div_shift_params.svh on the include path
`include "div_shift_params.svh"
`default_nettype none
package div_shift_pkg;
  typedef enum logic [2:0] {
    OP_DIV_S32 = 3'h0,
    OP_DIV_U32 = 3'h1,
    OP_DIV_S16 = 3'h2,
    OP_DIV_U16 = 3'h3,
    OP_ASR     = 3'h4,
    OP_LSR     = 3'h5,
    OP_SL      = 3'h6
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_DIV  = 2'h2
  } st_t;
  typedef struct packed {
    logic                  valid;
    op_t                   op;
    logic [`DS_IDX_W-1:0]  src;
    logic [`DS_IDX_W-1:0]  dvs;
    logic [`DS_IDX_W-1:0]  dst;
    logic [`DS_AMT_W-1:0]  amt;
  } req_t;
  typedef struct packed {
    logic                  en;
    logic [`DS_IDX_W-1:0]  idx;
    logic [`DS_DATA_W-1:0] data;
  } wr_t;
  typedef struct packed {
    st_t                                   st;
    logic [`DS_NREG-1:0][`DS_DATA_W-1:0]   rf;
    logic [`DS_DATA_W-1:0]                 rem;
    logic [`DS_DATA_W-1:0]                 quo;
    logic [`DS_DATA_W-1:0]                 dvs;
    logic [4:0]                            cnt;
    logic                                  neg_q;
    logic                                  neg_r;
    logic                                  done;
    logic [`DS_DATA_W-1:0]                 rd;
  } state_t;
endpackage
`default_nettype wire

// File: logic/div_shift_unit.sv
// divide and barrel shift unit with its working register file
// assumes: decoder holds requests while ready_o is low and
// leaves the register file alone while busy_o is high
`include "div_shift_params.svh"
`default_nettype none
module div_shift_unit
  import div_shift_pkg::*;
#(
  parameter int DIV_ITER = `DS_DIV_ITER
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire req_t                  req_i,
  output logic                       ready_o,
  output logic                       busy_o,
  output logic                       done_o,
  input  wire wr_t                   wr_i,
  input  wire logic [`DS_IDX_W-1:0]  rd_idx_i,
  output logic [`DS_DATA_W-1:0]      rd_data_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] neg16(input logic [15:0] x);
    return 16'(~x + 16'h0001);
  endfunction

  // one restoring step: shift in next dividend bit, trial subtract
  function automatic logic [31:0] div_step(input logic [15:0] rem,
                                           input logic [15:0] quo,
                                           input logic [15:0] dvs);
    logic [16:0] r;
    logic [16:0] t;
    r = {rem, quo[15]};
    t = 17'(r - {1'b0, dvs});
    if (!t[16]) begin
      return {t[15:0], quo[14:0], 1'b1};
    end
    return {r[15:0], quo[14:0], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  localparam state_t RST_STATE = '{
    st: ST_IDLE, rf: '0, rem: `DS_RST_WORD, quo: `DS_RST_WORD,
    dvs: `DS_RST_WORD, cnt: 5'h00, neg_q: 1'b0, neg_r: 1'b0,
    done: 1'b0, rd: `DS_RST_WORD};

  localparam logic [4:0] LAST_CNT = 5'(DIV_ITER - 1);

  state_t q;
  state_t d;

  logic                  acc;
  logic                  is_div;
  logic                  is_sgn;
  logic                  is_32;
  logic [`DS_IDX_W-1:0]  lo_idx;
  logic [`DS_IDX_W-1:0]  hi_idx;
  logic [31:0]           dvd_w;
  logic [15:0]           dvs_w;
  logic [31:0]           dvd_mag;
  logic [15:0]           dvs_mag;
  logic [31:0]           stp;
  logic [15:0]           src_w;
  logic [15:0]           shf_w;

  assign ready_o   = q.st == ST_IDLE;
  assign busy_o    = q.st == ST_DIV;
  assign done_o    = q.done;
  assign rd_data_o = q.rd;

  assign acc    = req_i.valid && ready_o;
  assign is_div = !req_i.op[2];
  assign is_sgn = !req_i.op[0];
  assign is_32  = !req_i.op[1];

  // pair is forced even so an odd index cannot split a pair
  assign lo_idx = {req_i.src[`DS_IDX_W-1:1], 1'b0};
  assign hi_idx = {req_i.src[`DS_IDX_W-1:1], 1'b1};

  always_comb begin
    dvs_w = q.rf[req_i.dvs];
    if (is_32) begin
      dvd_w = {q.rf[hi_idx], q.rf[lo_idx]};
    end else if (is_sgn) begin
      dvd_w = {{16{q.rf[req_i.src][15]}}, q.rf[req_i.src]};
    end else begin
      dvd_w = {16'h0000, q.rf[req_i.src]};
    end
    dvd_mag = (is_sgn && dvd_w[31]) ? 32'(~dvd_w + 32'h0000_0001)
                                    : dvd_w;
    dvs_mag = (is_sgn && dvs_w[15]) ? neg16(dvs_w) : dvs_w;
  end

  ////////////////////////////////////////////////////////////////////////
  // barrel shifter: all amounts settle in one pass

  always_comb begin
    src_w = q.rf[req_i.src];
    unique case (req_i.op)
      OP_ASR:  shf_w = 16'($signed(src_w) >>> req_i.amt);
      OP_LSR:  shf_w = src_w >> req_i.amt;
      OP_SL:   shf_w = src_w << req_i.amt;
      default: shf_w = src_w;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  assign stp = div_step(q.rem, q.quo, q.dvs);

  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.rd   = q.rf[rd_idx_i];
    if (wr_i.en) begin
      d.rf[wr_i.idx] = wr_i.data;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (acc && is_div) begin
          // partial remainder starts as high half, low half shifts in
          d.st    = ST_DIV;
          d.rem   = dvd_mag[31:16];
          d.quo   = dvd_mag[15:0];
          d.dvs   = dvs_mag;
          d.cnt   = 5'h00;
          d.neg_q = is_sgn && (dvd_w[31] ^ dvs_w[15]);
          d.neg_r = is_sgn && dvd_w[31];
        end else if (acc && req_i.op != 3'h7) begin
          d.rf[req_i.dst] = shf_w;
          d.done          = 1'b1;
        end
      end
      ST_DIV: begin
        d.rem = stp[31:16];
        d.quo = stp[15:0];
        d.cnt = 5'(q.cnt + 5'h01);
        if (q.cnt == LAST_CNT) begin
          // overflow and zero divisor give unspecified but defined values
          d.st  = ST_IDLE;
          d.done = 1'b1;
          d.rf[`DS_QUO_IDX] = q.neg_q ? neg16(stp[15:0])
                                      : stp[15:0];
          d.rf[`DS_REM_IDX] = q.neg_r ? neg16(stp[31:16])
                                      : stp[31:16];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  localparam int LAT = 17;

  logic acc_div;
  logic acc_shf;
  logic ok_s16;
  logic ok_u32;
  logic ok_s32;
  logic ok_u16;
  assign acc_div = acc && is_div;
  assign acc_shf = acc && !is_div && req_i.op != 3'h7;
  assign ok_s16  = acc_div && req_i.op == OP_DIV_S16 && dvs_w != 16'h0000
                   && !(dvd_w[15:0] == 16'h8000 && dvs_w == 16'hFFFF);
  assign ok_u32  = acc_div && req_i.op == OP_DIV_U32
                   && dvd_w[31:16] < dvs_w;
  // quotient magnitude under 2^15, so the signed result word holds it
  assign ok_s32  = acc_div && req_i.op == OP_DIV_S32
                   && {15'h0000, dvd_mag[31:15]} < {16'h0000, dvs_mag};
  // zero divisor left out: its result is defined but not specified
  assign ok_u16  = acc_div && req_i.op == OP_DIV_U16 && dvs_w != 16'h0000;

  // the step counter stands in for a long run of busy cycles, which
  // would be costly to unroll as a repetition
  sequence div_first_s;
    busy_o && !done_o && !ready_o && q.cnt == 5'h00;
  endsequence

  sequence div_last_s;
    busy_o && !done_o && !ready_o && q.cnt == LAST_CNT;
  endsequence

  sequence div_finish_s;
    done_o && ready_o;
  endsequence

  div_latency_a: assert property (
    acc_div |=> div_first_s ##15 div_last_s ##1 div_finish_s)
    else $error("divide did not finish in the fixed cycle count");

  div_stepping_a: assert property (
    busy_o && q.cnt != LAST_CNT |=>
      busy_o && !done_o && q.cnt == $past(q.cnt) + 5'h01)
    else $error("divide left its step sequence early");

  div_signed32_a: assert property (
    ok_s32 |-> ##LAT
      (int'($signed(q.rf[0])) * int'($signed($past(dvs_w, LAT)))
       + int'($signed(q.rf[1])) == int'($signed($past(dvd_w, LAT))))
      && (q.rf[1] == 16'h0000
          || q.rf[1][15] == $past(dvd_w[31], LAT)))
    else $error("signed long quotient or remainder wrong");

  div_unsigned16_a: assert property (
    ok_u16 |-> ##LAT
      ({16'h0000, q.rf[0]} * {16'h0000, $past(dvs_w, LAT)}
       + {16'h0000, q.rf[1]} == $past(dvd_w, LAT))
      && q.rf[1] < $past(dvs_w, LAT))
    else $error("unsigned short quotient or remainder wrong");

  div_signed_a: assert property (
    ok_s16 |-> ##LAT
      (int'($signed(q.rf[0])) * int'($signed($past(dvs_w, LAT)))
       + int'($signed(q.rf[1])) == int'($signed($past(dvd_w, LAT))))
      && (q.rf[1] == 16'h0000
          || q.rf[1][15] == $past(dvd_w[15], LAT)))
    else $error("signed quotient or remainder wrong");

  div_unsigned_a: assert property (
    ok_u32 |-> ##LAT
      ({16'h0000, q.rf[0]} * {16'h0000, $past(dvs_w, LAT)}
       + {16'h0000, q.rf[1]} == $past(dvd_w, LAT))
      && q.rf[1] < $past(dvs_w, LAT))
    else $error("unsigned quotient or remainder wrong");

  shf_asr_a: assert property (
    acc_shf && req_i.op == OP_ASR |=>
      q.rf[$past(req_i.dst)] ==
      16'($signed($past(src_w)) >>> $past(req_i.amt)))
    else $error("arithmetic right shift wrong");

  shf_left_a: assert property (
    acc_shf && req_i.op == OP_SL |=>
      q.rf[$past(req_i.dst)] == 16'($past(src_w) << $past(req_i.amt)))
    else $error("left shift wrong");

  shf_logic_a: assert property (
    acc_shf && req_i.op == OP_LSR |=>
      q.rf[$past(req_i.dst)] == ($past(src_w) >> $past(req_i.amt)))
    else $error("logical right shift wrong");

  shf_one_cycle_a: assert property (
    acc_shf |=> done_o && ready_o)
    else $error("shift took more than one cycle");

  busy_excl_a: assert property (
    busy_o |-> !ready_o && !done_o)
    else $error("busy overlaps ready or done");

  // fill bits checked on their own so a wrong fill cannot hide
  shf_sign_fill_a: assert property (
    acc_shf && req_i.op == OP_ASR |=>
      q.rf[$past(req_i.dst)][15] == $past(src_w[15]))
    else $error("arithmetic right shift lost the sign");

  shf_top_zero_a: assert property (
    acc_shf && req_i.op == OP_LSR && req_i.amt != 4'h0 |=>
      !q.rf[$past(req_i.dst)][15])
    else $error("logical right shift did not clear the top bit");

  shf_low_zero_a: assert property (
    acc_shf && req_i.op == OP_SL && req_i.amt != 4'h0 |=>
      !q.rf[$past(req_i.dst)][0])
    else $error("left shift did not clear the low bit");

  // amount zero is the plain copy case
  shf_zero_amt_a: assert property (
    acc_shf && req_i.amt == 4'h0 |=>
      q.rf[$past(req_i.dst)] == $past(src_w))
    else $error("zero amount shift did not copy the source");

  // a shift must not disturb the quotient register
  shf_dst_only_a: assert property (
    acc_shf && !wr_i.en && req_i.dst != `DS_QUO_IDX |=>
      q.rf[`DS_QUO_IDX] == $past(q.rf[`DS_QUO_IDX]))
    else $error("shift wrote outside its destination");

  // shifts never leave idle; only an accepted divide does
  idle_hold_a: assert property (
    ready_o && !acc_div |=> ready_o)
    else $error("unit left idle without a divide");

  done_pulse_a: assert property (
    done_o && !acc_shf |=> !done_o)
    else $error("done held longer than one cycle");

endmodule
`default_nettype wire

// File: testbench/decoder_model.sv
// decoder model: presents one unit request and holds it until taken
// assumes: called from the bench at falling edges; the unit samples
// on rising edges
`default_nettype none
module decoder_model
  import div_shift_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic ready_i,
  output var  req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  // a request is held while the unit is busy, never dropped early
  task automatic issue(input req_t r);
    req_o = r;
    while (ready_i !== 1'b1) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    // released fields flip so nothing leans on stale values
    req_o = ~r;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_divide_and_barrel_shift_unit.sv
// bench for the divide and barrel shift unit
// assumes: decoder model drives requests, bench drives register file
`default_nettype none
module test_divide_and_barrel_shift_unit
  import div_shift_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  req_t        req;
  wr_t         wr_i      = '0;
  logic [3:0]  rd_idx_i  = 4'h0;
  logic        ready_o;
  logic        busy_o;
  logic        done_o;
  logic [15:0] rd_data_o;
  int          fails     = 0;
  int          checked   = 0;
  int          cycles    = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  div_shift_unit #(.DIV_ITER(16)) div_shift_unit_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .ready_o(ready_o), .busy_o(busy_o), .done_o(done_o),
    .wr_i(wr_i), .rd_idx_i(rd_idx_i), .rd_data_o(rd_data_o));
  decoder_model decoder_model_inst (
    .ref_clk_i(ref_clk_i), .ready_i(ready_o), .req_o(req));
  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] v);
    wr_i = '{1'b1, i, v};
    @(negedge ref_clk_i);
    wr_i = '0;
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [3:0] i, input logic [15:0] e);
    rd_idx_i = i;
    @(negedge ref_clk_i);
    chk(rd_data_o, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic dv(input op_t op, input logic [3:0] lo, dvi,
                    input logic [15:0] hi_v, lo_v, d_v);
    longint n, m, eq, er;
    if (op == OP_DIV_S32 || op == OP_DIV_U32) wr(lo | 4'h1, hi_v);
    wr(lo, lo_v);
    wr(dvi, d_v);
    case (op)
      OP_DIV_S32: n = longint'($signed({hi_v, lo_v}));
      OP_DIV_U32: n = longint'({hi_v, lo_v});
      OP_DIV_S16: n = longint'($signed(lo_v));
      default:    n = longint'(lo_v);
    endcase
    if (op == OP_DIV_S32 || op == OP_DIV_S16) m = longint'($signed(d_v));
    else m = longint'(d_v);
    eq = n / m;
    er = n % m;
    decoder_model_inst.issue('{1'b1, op, lo, dvi, 4'h0, 4'h0});
    for (int k = 0; k < 16; k++) begin
      chk(16'({busy_o, done_o}), 16'h0002);
      @(negedge ref_clk_i);
    end
    chk(16'({busy_o, done_o}), 16'h0001);
    rd(4'h0, eq[15:0]);
    rd(4'h1, er[15:0]);
  endtask
  task automatic sh(input op_t op, input logic [3:0] s, dst, amt,
                    input logic [15:0] v);
    logic [15:0] e;
    case (op)
      OP_ASR:  e = $signed(v) >>> amt;
      OP_LSR:  e = v >> amt;
      default: e = v << amt;
    endcase
    wr(s, v);
    decoder_model_inst.issue('{1'b1, op, s, 4'h0, dst, amt});
    chk(16'(done_o), 16'h0001);
    rd(dst, e);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(16'({ready_o, busy_o, done_o}), 16'h0004);
    rd(4'h7, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_divide();
    dv(OP_DIV_S32, 4'h6, 4'h9, 16'hFFFE, 16'h7960, 16'h0007);
    dv(OP_DIV_U32, 4'hA, 4'hF, 16'h0012, 16'h3456, 16'h1234);
    dv(OP_DIV_S16, 4'h4, 4'hC, 16'h0000, 16'h8001, 16'hFFFD);
    // operands in the result registers themselves
    dv(OP_DIV_U16, 4'h0, 4'h1, 16'h0000, 16'hFFFF, 16'h0010);
    $display("test divide done");
  endtask
  task automatic t_shift();
    sh(OP_ASR, 4'h2, 4'h5, 4'hF, 16'h8421);
    sh(OP_ASR, 4'h2, 4'h5, 4'h1, 16'h8421);
    sh(OP_LSR, 4'h3, 4'hE, 4'hF, 16'h8421);
    sh(OP_LSR, 4'h3, 4'h3, 4'h4, 16'hF0F0);
    sh(OP_SL,  4'h8, 4'hB, 4'hF, 16'h8421);
    sh(OP_SL,  4'h8, 4'hB, 4'h4, 16'h8421);
    sh(OP_SL,  4'h8, 4'hB, 4'h0, 16'h8421);
    $display("test shift done");
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_divide();
    t_shift();
    tally_and_finish();
  end
endmodule
`default_nettype wire
